// ===== hw/qngw_defs.vh
// Register indices, field positions, reset values and timing counts of the nibble GPIO block
`ifndef QNGW_DEFS_VH
`define QNGW_DEFS_VH
// Register indices; byte address is four times the index
`define QNGW_IDX_E_DIR 6'h01
`define QNGW_IDX_A_DIR 6'h02
`define QNGW_IDX_A_VAL 6'h03
`define QNGW_IDX_B_DIR 6'h05
`define QNGW_IDX_B_VAL 6'h06
`define QNGW_IDX_D_DIR 6'h0C
`define QNGW_IDX_D_VAL 6'h0D
`define QNGW_IDX_E_VAL 6'h0E
`define QNGW_IDX_IBC 6'h11
`define QNGW_IDX_INT_STATUS 6'h18
`define QNGW_IDX_INT_MASK 6'h19
// Input buffer control fields
`define QNGW_IBC_TWOS_BIT 1
`define QNGW_IBC_HYST_BIT 2
`define QNGW_IBC_MASK 4'h6
// Interrupt status fields
`define QNGW_INT_WAKE_BIT 0
`define QNGW_INT_EDGE_BIT 1
// Reset values
`define QNGW_DIR_RST 4'h0
`define QNGW_VAL_RST 4'h0
`define QNGW_IBC_RST 4'h0
`define QNGW_INT_RST 2'h0
// Wake vector address
`define QNGW_WAKE_VECTOR 12'h004
// Carrier timing: half period in cycles rounds down from clock rate and carrier rate
`define QNGW_CLK_HZ 25000000
`define QNGW_CARRIER_HZ 38000
`define QNGW_CARRIER_HALF (`QNGW_CLK_HZ / (2 * `QNGW_CARRIER_HZ))
`define QNGW_CARRIER_CW 9
`endif

// ===== hw/qngw_pad.v
// Pad control of one 4-bit port: direction, output latch, pull-downs, input sampling
`default_nettype none
module qngw_pad (
  input wire mclk,
  input wire rst,
  input wire [3:0] dir,
  input wire [3:0] latch,
  input wire [3:0] pin_in,
  input wire [3:0] strong_fuse,
  input wire [3:0] weak_fuse,
  input wire [3:0] force_low,
  input wire [3:0] carrier_sel,
  input wire carrier_level,
  input wire [3:0] release_pin,
  output reg [3:0] pin_out,
  output reg [3:0] pin_oe,
  output reg [3:0] pd_strong,
  output reg [3:0] pd_weak,
  output reg [3:0] sample,
  output wire [3:0] read_val
);
  wire [3:0] drive = dir & ~release_pin;

  // Output latch for outputs, sampled pin for inputs
  assign read_val = (dir & latch) | (~dir & sample);

  // Pad drive and pull-downs; forced low wins over carrier and latch
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out <= 4'h0;
      pin_oe <= 4'h0;
      pd_strong <= 4'h0;
      pd_weak <= 4'h0;
      sample <= 4'h0;
    end else begin
      sample <= pin_in;
      pin_oe <= drive | force_low;
      pin_out <= ~force_low & ((carrier_sel & latch & {4{carrier_level}}) | (~carrier_sel & latch));
      // Pull-downs only on pins left as inputs
      pd_strong <= ~(drive | force_low) & ~release_pin & strong_fuse;
      pd_weak <= ~(drive | force_low) & ~release_pin & weak_fuse;
    end
  end
endmodule
`default_nettype wire

// ===== hw/qngw_top.v
// Top of the nibble GPIO block: register slave, wake sequencing, carrier and interrupt
`include "qngw_defs.vh"
`default_nettype none
//
// Contract
// - Direction bit 1 makes pin output, 0 input; all clear on reset.
// - Output pins drive the value latch; reading returns the latch.
// - Input pins read back the sampled external pin level.
// - Pull-down off in output mode; in input mode only if fused on.
// - Halted, rising edge on wake-enabled pin restarts clock and jumps to vector.
// - Dual-edge option makes falling edges wake as well.
// - Carrier option: port A bit 3 output emits 38 kHz when bit set.
// - During halt port A bit 3 is forced to a low output.
// - Control bit enables hysteresis inputs on all sixteen pins; reset off.
// - Control bit picks two's complement or sign-magnitude audio samples.
// - Direction and value registers decode at their fixed addresses.
// - Wake enable is fused per pin for each of four ports.
// - Strong and weak pull-downs are fused per pin on all ports.
// - Fuse chooses port B bit 3 as I/O or active-low reset input.
module qngw_top (
  input wire mclk,
  input wire rst,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  input wire halt,
  output wire osc_wake,
  output reg pc_load,
  output wire [11:0] wake_vector,
  output wire irq,
  output wire hysteresis_input_enable,
  output wire pwm_twos_complement_select,
  output wire ext_reset_n,
  input wire ir_carrier_enable,
  input wire dual_edge_wake,
  input wire port_b3_reset_select,
  input wire [3:0] port_a_wake_enable,
  input wire [3:0] port_b_wake_enable,
  input wire [3:0] port_d_wake_enable,
  input wire [3:0] port_e_wake_enable,
  input wire [3:0] port_a_strong_pulldown,
  input wire [3:0] port_b_strong_pulldown,
  input wire [3:0] port_d_strong_pulldown,
  input wire [3:0] port_e_strong_pulldown,
  input wire [3:0] port_a_weak_pulldown,
  input wire [3:0] port_b_weak_pulldown,
  input wire [3:0] port_d_weak_pulldown,
  input wire [3:0] port_e_weak_pulldown,
  input wire [3:0] pin_a_in,
  output wire [3:0] pin_a_out,
  output wire [3:0] pin_a_oe,
  output wire [3:0] pin_a_pd_strong,
  output wire [3:0] pin_a_pd_weak,
  input wire [3:0] pin_b_in,
  output wire [3:0] pin_b_out,
  output wire [3:0] pin_b_oe,
  output wire [3:0] pin_b_pd_strong,
  output wire [3:0] pin_b_pd_weak,
  input wire [3:0] pin_d_in,
  output wire [3:0] pin_d_out,
  output wire [3:0] pin_d_oe,
  output wire [3:0] pin_d_pd_strong,
  output wire [3:0] pin_d_pd_weak,
  input wire [3:0] pin_e_in,
  output wire [3:0] pin_e_out,
  output wire [3:0] pin_e_oe,
  output wire [3:0] pin_e_pd_strong,
  output wire [3:0] pin_e_pd_weak
);
  // Zero-extend a nibble to a bus word
  function [31:0] nib32;
    input [3:0] n;
    begin
      nib32 = {28'h0000000, n};
    end
  endfunction

  // Software-visible registers
  reg [3:0] port_a_direction_reg;
  reg [3:0] port_b_direction_reg;
  reg [3:0] port_d_direction_reg;
  reg [3:0] port_e_direction_reg;
  reg [3:0] port_a_value_reg;
  reg [3:0] port_b_value_reg;
  reg [3:0] port_d_value_reg;
  reg [3:0] port_e_value_reg;
  reg [3:0] input_buffer_control_reg;
  reg [1:0] int_status_reg;
  reg [1:0] int_status_next;
  reg [1:0] int_mask_reg;
  // Bus handshake and wake sequencing
  reg ack_reg;
  reg wake_meta_reg;
  reg wake_sync_reg;
  reg wake_prev_reg;
  reg [15:0] edge_prev_reg;
  // Carrier generator
  reg [`QNGW_CARRIER_CW-1:0] carrier_cnt_reg;
  reg carrier_level_reg;
  reg [31:0] read_word;

  wire [5:0] index = address[7:2];
  wire access = read | write;
  wire wr_take = write & ack_reg;
  wire [3:0] wd = writedata[3:0];
  wire [3:0] a_read;
  wire [3:0] b_read;
  wire [3:0] d_read;
  wire [3:0] e_read;
  wire [3:0] a_sample;
  wire [3:0] b_sample;
  wire [3:0] d_sample;
  wire [3:0] e_sample;
  wire [15:0] all_pins = {pin_e_in, pin_d_in, pin_b_in, pin_a_in};
  wire [15:0] all_samples = {e_sample, d_sample, b_sample, a_sample};
  wire [15:0] wake_fuse = {port_e_wake_enable, port_d_wake_enable, port_b_wake_enable, port_a_wake_enable};
  wire [15:0] arm_rise = wake_fuse & {16{halt}};
  wire [15:0] arm_fall = wake_fuse & {16{halt & dual_edge_wake}};
  wire [3:0] a3_carrier = {ir_carrier_enable, 3'b000};
  wire [3:0] a3_force = {halt, 3'b000};
  wire [3:0] b3_release = {port_b3_reset_select, 3'b000};
  wire [15:0] edge_seen = (all_samples ^ edge_prev_reg) & wake_fuse;

  // One wait state: waitrequest high in the first cycle of each access
  assign waitrequest = access & ~ack_reg;
  assign wake_vector = `QNGW_WAKE_VECTOR;
  assign hysteresis_input_enable = input_buffer_control_reg[`QNGW_IBC_HYST_BIT];
  assign pwm_twos_complement_select = input_buffer_control_reg[`QNGW_IBC_TWOS_BIT];
  // Port B bit 3 doubles as the active-low reset when fused so
  assign ext_reset_n = port_b3_reset_select ? pin_b_in[3] : 1'b1;
  assign irq = |(int_status_reg & int_mask_reg);

  // Read mux; unmapped indices answer zero
  always @* begin
    read_word = 32'h00000000;
    case (index)
      `QNGW_IDX_E_DIR: read_word = nib32(port_e_direction_reg);
      `QNGW_IDX_A_DIR: read_word = nib32(port_a_direction_reg);
      `QNGW_IDX_A_VAL: read_word = nib32(a_read);
      `QNGW_IDX_B_DIR: read_word = nib32(port_b_direction_reg);
      `QNGW_IDX_B_VAL: read_word = nib32(b_read);
      `QNGW_IDX_D_DIR: read_word = nib32(port_d_direction_reg);
      `QNGW_IDX_D_VAL: read_word = nib32(d_read);
      `QNGW_IDX_E_VAL: read_word = nib32(e_read);
      `QNGW_IDX_IBC: read_word = nib32(input_buffer_control_reg);
      `QNGW_IDX_INT_STATUS: read_word = nib32({2'b00, int_status_reg});
      `QNGW_IDX_INT_MASK: read_word = nib32({2'b00, int_mask_reg});
      default: read_word = 32'h00000000;
    endcase
  end

  // Bus handshake; read data is captured in the wait cycle and stands at the taking edge
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      ack_reg <= access & ~ack_reg;
      if (read & ~ack_reg) begin
        readdata <= read_word;
      end
    end
  end

  // Register writes take effect at the edge where waitrequest is low
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_a_direction_reg <= `QNGW_DIR_RST;
      port_b_direction_reg <= `QNGW_DIR_RST;
      port_d_direction_reg <= `QNGW_DIR_RST;
      port_e_direction_reg <= `QNGW_DIR_RST;
      port_a_value_reg <= `QNGW_VAL_RST;
      port_b_value_reg <= `QNGW_VAL_RST;
      port_d_value_reg <= `QNGW_VAL_RST;
      port_e_value_reg <= `QNGW_VAL_RST;
      input_buffer_control_reg <= `QNGW_IBC_RST;
      int_mask_reg <= `QNGW_INT_RST;
    end else if (wr_take) begin
      case (index)
        `QNGW_IDX_E_DIR: port_e_direction_reg <= wd;
        `QNGW_IDX_A_DIR: port_a_direction_reg <= wd;
        `QNGW_IDX_B_DIR: port_b_direction_reg <= wd;
        `QNGW_IDX_D_DIR: port_d_direction_reg <= wd;
        // Latch loads whatever the direction, so it shows when the pin turns output
        `QNGW_IDX_A_VAL: port_a_value_reg <= wd;
        `QNGW_IDX_B_VAL: port_b_value_reg <= wd;
        `QNGW_IDX_D_VAL: port_d_value_reg <= wd;
        `QNGW_IDX_E_VAL: port_e_value_reg <= wd;
        `QNGW_IDX_IBC: input_buffer_control_reg <= wd & `QNGW_IBC_MASK;
        `QNGW_IDX_INT_MASK: int_mask_reg <= wd[1:0];
        default: port_a_value_reg <= port_a_value_reg;
      endcase
    end
  end

  // Sticky status: hardware set wins over a write-one clear in the same cycle
  always @* begin
    int_status_next = int_status_reg;
    if (wr_take && index == `QNGW_IDX_INT_STATUS) begin
      int_status_next = int_status_reg & ~wd[1:0];
    end
    if (wake_sync_reg & ~wake_prev_reg) begin
      int_status_next[`QNGW_INT_WAKE_BIT] = 1'b1;
    end
    if (|edge_seen) begin
      int_status_next[`QNGW_INT_EDGE_BIT] = 1'b1;
    end
  end

  // Wake request crosses from the clockless latches; its synced level also clears them
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
      wake_prev_reg <= 1'b0;
      pc_load <= 1'b0;
      edge_prev_reg <= 16'h0000;
      int_status_reg <= `QNGW_INT_RST;
    end else begin
      wake_meta_reg <= osc_wake;
      wake_sync_reg <= wake_meta_reg;
      wake_prev_reg <= wake_sync_reg;
      pc_load <= wake_sync_reg & ~wake_prev_reg;
      edge_prev_reg <= all_samples;
      int_status_reg <= int_status_next;
    end
  end

  // Carrier square wave; free-running, so the first half period after enable can be short
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      carrier_cnt_reg <= {`QNGW_CARRIER_CW{1'b0}};
      carrier_level_reg <= 1'b0;
    end else if (carrier_cnt_reg == `QNGW_CARRIER_HALF - 1) begin
      carrier_cnt_reg <= {`QNGW_CARRIER_CW{1'b0}};
      carrier_level_reg <= ~carrier_level_reg;
    end else begin
      carrier_cnt_reg <= carrier_cnt_reg + 1'b1;
    end
  end

  // Edge latches; cleared by rst or once the synced request is seen by the core side
  qngw_wake u_wake (
    .clr(rst | wake_sync_reg),
    .pins(all_pins),
    .arm_rise(arm_rise),
    .arm_fall(arm_fall),
    .wake_async(osc_wake)
  );

  qngw_pad u_pad_a (
    .mclk(mclk),
    .rst(rst),
    .dir(port_a_direction_reg),
    .latch(port_a_value_reg),
    .pin_in(pin_a_in),
    .strong_fuse(port_a_strong_pulldown),
    .weak_fuse(port_a_weak_pulldown),
    .force_low(a3_force),
    .carrier_sel(a3_carrier),
    .carrier_level(carrier_level_reg),
    .release_pin(4'h0),
    .pin_out(pin_a_out),
    .pin_oe(pin_a_oe),
    .pd_strong(pin_a_pd_strong),
    .pd_weak(pin_a_pd_weak),
    .sample(a_sample),
    .read_val(a_read)
  );

  qngw_pad u_pad_b (
    .mclk(mclk),
    .rst(rst),
    .dir(port_b_direction_reg),
    .latch(port_b_value_reg),
    .pin_in(pin_b_in),
    .strong_fuse(port_b_strong_pulldown),
    .weak_fuse(port_b_weak_pulldown),
    .force_low(4'h0),
    .carrier_sel(4'h0),
    .carrier_level(carrier_level_reg),
    .release_pin(b3_release),
    .pin_out(pin_b_out),
    .pin_oe(pin_b_oe),
    .pd_strong(pin_b_pd_strong),
    .pd_weak(pin_b_pd_weak),
    .sample(b_sample),
    .read_val(b_read)
  );

  qngw_pad u_pad_d (
    .mclk(mclk),
    .rst(rst),
    .dir(port_d_direction_reg),
    .latch(port_d_value_reg),
    .pin_in(pin_d_in),
    .strong_fuse(port_d_strong_pulldown),
    .weak_fuse(port_d_weak_pulldown),
    .force_low(4'h0),
    .carrier_sel(4'h0),
    .carrier_level(carrier_level_reg),
    .release_pin(4'h0),
    .pin_out(pin_d_out),
    .pin_oe(pin_d_oe),
    .pd_strong(pin_d_pd_strong),
    .pd_weak(pin_d_pd_weak),
    .sample(d_sample),
    .read_val(d_read)
  );

  qngw_pad u_pad_e (
    .mclk(mclk),
    .rst(rst),
    .dir(port_e_direction_reg),
    .latch(port_e_value_reg),
    .pin_in(pin_e_in),
    .strong_fuse(port_e_strong_pulldown),
    .weak_fuse(port_e_weak_pulldown),
    .force_low(4'h0),
    .carrier_sel(4'h0),
    .carrier_level(carrier_level_reg),
    .release_pin(4'h0),
    .pin_out(pin_e_out),
    .pin_oe(pin_e_oe),
    .pd_strong(pin_e_pd_strong),
    .pd_weak(pin_e_pd_weak),
    .sample(e_sample),
    .read_val(e_read)
  );
endmodule
`default_nettype wire

// ===== hw/qngw_wake.v
// Clockless pin-edge wake latches for the sixteen port pins
`default_nettype none
module qngw_wake (
  input wire clr,
  input wire [15:0] pins,
  input wire [15:0] arm_rise,
  input wire [15:0] arm_fall,
  output wire wake_async
);
  wire [15:0] rise_q;
  wire [15:0] fall_q;
  genvar i;

  // Pin edges clock the latches, so no system clock is needed while halted
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_pin
      reg r_reg;
      reg f_reg;
      always @(posedge pins[i] or posedge clr) begin
        if (clr) begin
          r_reg <= 1'b0;
        end else begin
          r_reg <= arm_rise[i];
        end
      end
      always @(negedge pins[i] or posedge clr) begin
        if (clr) begin
          f_reg <= 1'b0;
        end else begin
          f_reg <= arm_fall[i];
        end
      end
      assign rise_q[i] = r_reg;
      assign fall_q[i] = f_reg;
    end
  endgenerate

  // Any caught edge restarts the oscillator
  assign wake_async = |(rise_q | fall_q);
endmodule
`default_nettype wire

// ===== verif/qngw_assertions.sv
// Checker of the nibble GPIO block's port relations
`default_nettype none
module qngw_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic halt,
  input wire logic osc_wake,
  input wire logic pc_load,
  input wire logic [11:0] wake_vector,
  input wire logic ext_reset_n,
  input wire logic port_b3_reset_select,
  input wire logic [3:0] pin_b_in,
  input wire logic [3:0] pin_b_oe,
  input wire logic [3:0] pin_a_out,
  input wire logic [3:0] pin_a_oe,
  input wire logic [3:0] pin_a_pd_strong,
  input wire logic [3:0] pin_a_pd_weak,
  input wire logic [3:0] pin_d_oe,
  input wire logic [3:0] pin_d_pd_weak
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Bus answer and wake start as steps
  sequence s_one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  sequence s_wake_start;
    halt && $rose(osc_wake);
  endsequence
  property p_one_wait;
    $rose(write) |-> s_one_wait;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("write not answered after one wait");
  // A pull-down fighting a driven pin wastes current
  property p_pd_off;
    (pin_a_oe & (pin_a_pd_strong | pin_a_pd_weak)) == 4'h0 && (pin_d_oe & pin_d_pd_weak) == 4'h0;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("pull-down on a driven pin");
  property p_halt_a3;
    halt |=> pin_a_oe[3] && !pin_a_out[3];
  endproperty
  a_halt_a3: assert property (p_halt_a3) else $error("IR pin not low in halt");
  property p_wake_pc;
    s_wake_start |-> ##[1:5] pc_load;
  endproperty
  a_wake_pc: assert property (p_wake_pc) else $error("no vector jump after wake");
  property p_vec;
    pc_load |-> wake_vector == 12'h004;
  endproperty
  a_vec: assert property (p_vec) else $error("wrong wake vector");
  property p_osc_clear;
    $rose(osc_wake) |-> ##[1:4] !osc_wake;
  endproperty
  a_osc_clear: assert property (p_osc_clear) else $error("wake latch not cleared");
  property p_pc_pulse;
    pc_load |=> !pc_load;
  endproperty
  a_pc_pulse: assert property (p_pc_pulse) else $error("vector load longer than a cycle");
  property p_b3_reset;
    ext_reset_n == (port_b3_reset_select ? pin_b_in[3] : 1'b1);
  endproperty
  a_b3_reset: assert property (p_b3_reset) else $error("reset input routing wrong");
  property p_b3_no_drive;
    port_b3_reset_select |=> !pin_b_oe[3];
  endproperty
  a_b3_no_drive: assert property (p_b3_no_drive) else $error("reset pin driven");
endmodule
bind qngw_top qngw_checker u_chk (.mclk, .rst, .write, .waitrequest, .halt, .osc_wake, .pc_load, .wake_vector,
  .ext_reset_n, .port_b3_reset_select, .pin_b_in, .pin_b_oe, .pin_a_out, .pin_a_oe, .pin_a_pd_strong,
  .pin_a_pd_weak, .pin_d_oe, .pin_d_pd_weak);
`default_nettype wire

// ===== verif/qngw_pin_model.sv
// Behavioural pins and attached circuits of one 4-bit port
`default_nettype none
module qngw_pin_model (
  input wire logic mclk,
  input wire logic [3:0] out,
  input wire logic [3:0] oe,
  input wire logic [3:0] pd,
  input wire logic [3:0] ext,
  input wire logic [3:0] ext_en,
  output logic [3:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] float_reg = 4'h5;
  // Unpulled free lines wander so a stale level never passes for a read
  always @(posedge mclk) float_reg <= ~float_reg;
  // Port driver wins, then the outside source, then the pull-down
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (oe[i]) lvl[i] = out[i];
      else if (ext_en[i]) lvl[i] = ext[i];
      else if (pd[i]) lvl[i] = 1'b0;
      else lvl[i] = float_reg[i];
    end
  end
endmodule
`default_nettype wire

// ===== verif/quad_nibble_gpio_wake_tb_top.sv
// Self-checking bench of the nibble GPIO block with its pins
`include "qngw_defs.vh"
`default_nettype none
module quad_nibble_gpio_wake_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0, write = 1'b0, halt = 1'b0;
  logic ir_carrier_enable = 1'b0, dual_edge_wake = 1'b0, port_b3_reset_select = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [3:0] fz_wake = 4'h2, fz_str = 4'h0, fz_weak = 4'hF, ext_b = 4'h0, ext_d = 4'h0, en_b = 4'hF, en_d = 4'h0;
  wire waitrequest, osc_wake, pc_load, irq, hyst, twos, ext_reset_n;
  wire [11:0] wake_vec;
  wire [31:0] readdata;
  wire [3:0] pin_a_in, pin_a_out, pin_a_oe, pin_a_pd_strong, pin_a_pd_weak;
  wire [3:0] pin_b_in, pin_b_out, pin_b_oe, pin_b_pd_strong, pin_b_pd_weak;
  wire [3:0] pin_d_in, pin_d_out, pin_d_oe, pin_d_pd_strong, pin_d_pd_weak;
  wire [3:0] pin_e_in, pin_e_out, pin_e_oe, pin_e_pd_strong, pin_e_pd_weak;
  logic [7:0] map_a [8] = '{8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h30, 8'h34, 8'h38};
  logic [3:0] map_d [8] = '{4'hF, 4'hF, 4'h3, 4'hF, 4'h6, 4'hF, 4'hC, 4'h9};
  int miscompares = 0, total_checks = 0;
  int n;
  initial forever #20 mclk = ~mclk;
  qngw_top DUT (.mclk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest, .halt, .osc_wake,
    .pc_load, .wake_vector(wake_vec), .irq, .hysteresis_input_enable(hyst), .pwm_twos_complement_select(twos),
    .ext_reset_n, .ir_carrier_enable, .dual_edge_wake, .port_b3_reset_select,
    .port_a_wake_enable(fz_wake), .port_b_wake_enable(fz_wake), .port_d_wake_enable(fz_wake),
    .port_e_wake_enable(fz_wake), .port_a_strong_pulldown(fz_str), .port_b_strong_pulldown(fz_str),
    .port_d_strong_pulldown(fz_str), .port_e_strong_pulldown(fz_str), .port_a_weak_pulldown(fz_weak),
    .port_b_weak_pulldown(fz_weak), .port_d_weak_pulldown(fz_weak), .port_e_weak_pulldown(fz_weak),
    .pin_a_in, .pin_a_out, .pin_a_oe, .pin_a_pd_strong, .pin_a_pd_weak,
    .pin_b_in, .pin_b_out, .pin_b_oe, .pin_b_pd_strong, .pin_b_pd_weak,
    .pin_d_in, .pin_d_out, .pin_d_oe, .pin_d_pd_strong, .pin_d_pd_weak,
    .pin_e_in, .pin_e_out, .pin_e_oe, .pin_e_pd_strong, .pin_e_pd_weak);
  // Pins of each port; only B and D see outside drivers
  qngw_pin_model pm_a (.mclk, .out(pin_a_out), .oe(pin_a_oe), .pd(pin_a_pd_strong | pin_a_pd_weak),
    .ext(4'h0), .ext_en(4'h0), .lvl(pin_a_in));
  qngw_pin_model pm_b (.mclk, .out(pin_b_out), .oe(pin_b_oe), .pd(pin_b_pd_strong | pin_b_pd_weak),
    .ext(ext_b), .ext_en(en_b), .lvl(pin_b_in));
  qngw_pin_model pm_d (.mclk, .out(pin_d_out), .oe(pin_d_oe), .pd(pin_d_pd_strong | pin_d_pd_weak),
    .ext(ext_d), .ext_en(en_d), .lvl(pin_d_in));
  qngw_pin_model pm_e (.mclk, .out(pin_e_out), .oe(pin_e_oe), .pd(pin_e_pd_strong | pin_e_pd_weak),
    .ext(4'h0), .ext_en(4'h0), .lvl(pin_e_in));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
  endtask
  // Hold the request until waitrequest is seen low at a rising edge
  task automatic wait_req();
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    address <= a;
    writedata <= {28'h0, d};
    write <= 1'b1;
    wait_req();
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    address <= a;
    read <= 1'b1;
    wait_req();
    q = readdata;
    read <= 1'b0;
    @(posedge mclk);
    chk(q, exp);
  endtask
  // Cycles until the IR pin changes level
  task automatic edge_gap(output int c);
    logic v;
    v = pin_a_out[3];
    for (c = 1; c < 1000; c++) begin
      @(posedge mclk);
      if (pin_a_out[3] !== v) break;
    end
  endtask
  // Halt, move port B, count vector loads
  task automatic try_wake(input logic [3:0] nb, input int exp);
    int p;
    halt <= 1'b1;
    tick(3);
    chk(pin_a_oe[3] & ~pin_a_out[3], 1'b1);
    ext_b <= nb;
    p = 0;
    repeat (12) begin
      @(posedge mclk);
      if (pc_load === 1'b1) p++;
    end
    chk(p, exp);
    halt <= 1'b0;
    tick(2);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (map_a[i]) if (map_d[i] == 4'hF) rc(map_a[i], 32'h0);
    rc(8'h44, 32'h0);
    chk(hyst, 1'b0);
    foreach (map_a[i]) wr(map_a[i], map_d[i]);
    foreach (map_a[i]) rc(map_a[i], {28'h0, map_d[i]});
    wr(8'h40, 4'h7);
    rc(8'h40, 32'h0);
    tick(2);
    chk({pin_a_oe, pin_a_out, pin_e_oe, pin_e_out}, 16'hF3F9);
    chk({pin_b_out, pin_d_out, pin_d_pd_weak}, 12'h6C0);
    // Latch loads while input and shows on turn-around
    wr(8'h14, 4'h0);
    wr(8'h18, 4'hA);
    tick(2);
    chk({pin_b_oe, pin_b_pd_weak, pin_b_pd_strong}, 12'h0F0);
    wr(8'h14, 4'hF);
    tick(2);
    chk(pin_b_out, 4'hA);
    en_d <= 4'hF;
    ext_d <= 4'h9;
    wr(8'h30, 4'h0);
    tick(3);
    rc(8'h34, 32'h9);
    ext_d <= 4'h6;
    tick(3);
    rc(8'h34, 32'h6);
    en_d <= 4'h0;
    tick(3);
    rc(8'h34, 32'h0);
    wr(8'h44, 4'hF);
    rc(8'h44, 32'h6);
    chk({hyst, twos}, 2'b11);
    wr(8'h44, 4'h2);
    chk({hyst, twos}, 2'b01);
    port_b3_reset_select <= 1'b1;
    tick(2);
    chk({ext_reset_n, pin_b_oe[3]}, 2'b00);
    ext_b <= 4'h8;
    tick(2);
    chk(ext_reset_n, 1'b1);
    port_b3_reset_select <= 1'b0;
    ext_b <= 4'h0;
    // Carrier free-runs and the latch write itself may flip the pin, so two gaps only align
    ir_carrier_enable <= 1'b1;
    wr(8'h0C, 4'h8);
    edge_gap(n);
    edge_gap(n);
    edge_gap(n);
    chk(n, `QNGW_CARRIER_HALF);
    wr(8'h0C, 4'h0);
    tick(2);
    chk(pin_a_out[3], 1'b0);
    ir_carrier_enable <= 1'b0;
    wr(8'h0C, 4'h8);
    tick(2);
    chk(pin_a_out[3], 1'b1);
    // Quiet inputs before halting: bit 1 of every port is wake-fused
    wr(8'h08, 4'h0);
    wr(8'h14, 4'h0);
    wr(8'h04, 4'h0);
    wr(8'h64, 4'h1);
    wr(8'h60, 4'h3);
    try_wake(4'h2, 1);
    chk(wake_vec, 12'h004);
    chk(irq, 1'b1);
    rc(8'h60, 32'h3);
    wr(8'h60, 4'h3);
    chk(irq, 1'b0);
    try_wake(4'h0, 0);
    fz_wake <= 4'h0;
    try_wake(4'h2, 0);
    fz_wake <= 4'h2;
    dual_edge_wake <= 1'b1;
    try_wake(4'h0, 1);
    try_wake(4'h2, 1);
    wr(8'h64, 4'h0);
    chk(irq, 1'b0);
    // All ports are inputs here, so every strong fuse shows on its pad
    fz_str <= 4'h5;
    tick(2);
    chk({pin_a_pd_strong, pin_b_pd_strong, pin_d_pd_strong, pin_e_pd_strong}, 16'h5555);
    // Reset in mid-run must drop drivers and return registers to their defaults
    wr(8'h14, 4'hF);
    rst <= 1'b1;
    tick(2);
    chk({pin_b_oe, pin_a_pd_strong, pin_e_pd_weak, pin_a_out}, 16'h0);
    rst <= 1'b0;
    tick(1);
    rc(8'h14, 32'h0);
    rc(8'h44, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
